// File: common/oag_pkg.sv
/*
 Shared types and constants for the operand address generator.
 Assumes a single clock domain and an APB register port.
*/
package oag_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int PADDR_W = 12;

    typedef enum logic [2:0] {
        MODE_REG = 3'h0,
        MODE_IMM = 3'h1,
        MODE_DP = 3'h2,
        MODE_ABS = 3'h3,
        MODE_IDX_X = 3'h4,
        MODE_IDX_X_INC = 3'h5,
        MODE_IDX_X_DP = 3'h6,
        MODE_ABS_IND = 3'h7
    } mode_t;

    typedef enum logic [2:0] {
        CLS_LOAD = 3'h0,
        CLS_STORE = 3'h1,
        CLS_CMP = 3'h2,
        CLS_ALU = 3'h3,
        CLS_RMW = 3'h4,
        CLS_XCHG = 3'h5,
        CLS_JUMP = 3'h6,
        CLS_OTHER = 3'h7
    } op_class_t;

    typedef enum logic [2:0] {
        SEL_A = 3'h0,
        SEL_X = 3'h1,
        SEL_Y = 3'h2,
        SEL_C = 3'h3,
        SEL_PSW = 3'h4
    } reg_sel_t;

    localparam logic [7:0] OPC_ADC_IMM = 8'h04;
    localparam logic [7:0] X_STEP = 8'h01;
    localparam int PSW_C_BIT = 0;
    localparam int PSW_G_BIT = 5;
    localparam int SHIFT_MSB = 7;

    // Register indices; byte address is index times four
    localparam logic [9:0] IDX_ACC = 10'h000;
    localparam logic [9:0] IDX_XREG = 10'h001;
    localparam logic [9:0] IDX_YREG = 10'h002;
    localparam logic [9:0] IDX_PSW = 10'h003;
    localparam logic [9:0] IDX_PAGE = 10'h0E1;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef struct packed {
        mode_t mode;
        op_class_t op_class;
        reg_sel_t reg_sel;
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
    } req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] operand;
        logic mem;
        logic rmw;
        logic illegal;
    } res_t;
endpackage

// File: hw/oag_adder.sv
/*
 Width-parameterised adder with carry in and carry out.
 Purely combinational; the caller registers the result.
*/
module oag_adder #(
    parameter int W = 8
) (
    // Operands
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    input wire logic cin_i,
    // Result
    output logic [W-1:0] sum_o,
    output logic cout_o
);
    logic [W:0] full;

    if (W < 1) begin
        $error("oag_adder: W must be positive");
    end

    always_comb begin
        full = (W+1)'(a_i) + (W+1)'(b_i) + (W+1)'(cin_i);
        sum_o = full[W-1:0];
        cout_o = full[W];
    end
endmodule

// File: hw/oag_ptr_fetch.sv
/*
 Two-byte pointer fetch for the absolute indirect jump.
 Assumes a same-clock memory port that answers a held request with a
 one-cycle read-valid pulse.
*/
module oag_ptr_fetch
    import oag_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Start
    input wire logic start_i,
    input wire logic [ADDR_W-1:0] ptr_i,
    // Memory port
    output logic mem_req_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    input wire logic mem_rvalid_i,
    // Result
    output logic pc_load_o,
    output logic [ADDR_W-1:0] pc_o,
    output logic idle_o
);
    typedef enum logic [1:0] {
        F_IDLE = 2'h0,
        F_LO = 2'h1,
        F_HI = 2'h3,
        F_LOAD = 2'h2
    } fstate_t;

    fstate_t state_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] pc_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= F_IDLE;
        end else begin
            unique case (state_r)
                F_IDLE: if (start_i) state_r <= F_LO;
                F_LO: if (mem_rvalid_i) state_r <= F_HI;
                F_HI: if (mem_rvalid_i) state_r <= F_LOAD;
                F_LOAD: state_r <= F_IDLE;
            endcase
        end
    end

    // Low byte first, then the byte at the next address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_r <= '0;
            pc_r <= '0;
        end else if (state_r == F_IDLE && start_i) begin
            addr_r <= ptr_i;
        end else if (state_r == F_LO && mem_rvalid_i) begin
            addr_r <= ADDR_W'(addr_r + ADDR_W'(1));
            pc_r[DATA_W-1:0] <= mem_rdata_i;
        end else if (state_r == F_HI && mem_rvalid_i) begin
            pc_r[ADDR_W-1:DATA_W] <= mem_rdata_i;
        end
    end

    assign mem_req_o = (state_r == F_LO) || (state_r == F_HI);
    assign mem_addr_o = addr_r;
    assign pc_load_o = (state_r == F_LOAD);
    assign pc_o = pc_r;
    assign idle_o = (state_r == F_IDLE);

    property p_ptr_step;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == F_LO && mem_rvalid_i) |=> mem_addr_o == $past(mem_addr_o) + 16'h0001;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer high byte address wrong");

    property p_pc_from_bytes;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == F_HI && mem_rvalid_i) |=> pc_load_o && pc_o[ADDR_W-1:DATA_W] == $past(mem_rdata_i);
    endproperty
    a_pc_from_bytes: assert property (p_pc_from_bytes) else $error("jump target high byte wrong");
endmodule

// File: hw/operand_address_generator.sv
/*
 Operand address generator of an 8-bit CPU core: turns opcode, operand
 bytes, X and the RAM page register into data addresses, and executes
 the few register updates tied to addressing.
 Assumes one clock, an APB master for the registers and a same-clock
 memory port for the indirect jump pointer.
*/
module operand_address_generator
    import oag_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // APB register port
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [oag_pkg::PADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Instruction request
    input wire logic REQ_VALID_I,
    input wire oag_pkg::req_t REQ_I,
    output logic REQ_READY_O,
    // Address result
    output logic RES_VALID_O,
    output oag_pkg::res_t RES_O,
    // Pointer memory port
    output logic MEM_REQ_O,
    output logic [oag_pkg::ADDR_W-1:0] MEM_ADDR_O,
    input wire logic [oag_pkg::DATA_W-1:0] MEM_RDATA_I,
    input wire logic MEM_RVALID_I,
    // Program counter load
    output logic PC_LOAD_O,
    output logic [oag_pkg::ADDR_W-1:0] PC_O
);
    import oag_pkg::*;

    logic [7:0] acc_r;
    logic [7:0] x_r;
    logic [7:0] y_r;
    logic [7:0] psw_r;
    logic [7:0] page_r;
    res_t res_r;
    res_t res_nxt;
    logic res_valid_r;
    logic [31:0] prdata_r;
    logic fire;
    logic ok;
    logic fetch_idle;
    logic fetch_start;
    logic [7:0] adc_sum;
    logic adc_cout;
    logic [7:0] dpx_sum;
    logic [7:0] xinc_sum;
    logic [9:0] idx;
    logic mapped;
    logic apb_wr;
    logic is_adc;
    logic is_asl;
    logic is_inc;
    logic [7:0] rd_byte;

    oag_adder #(.W(DATA_W)) u_adc (
        .a_i(acc_r),
        .b_i(REQ_I.op1),
        .cin_i(psw_r[PSW_C_BIT]),
        .sum_o(adc_sum),
        .cout_o(adc_cout)
    );

    oag_adder #(.W(DATA_W)) u_dpx (
        .a_i(x_r),
        .b_i(REQ_I.op1),
        .cin_i(1'b0),
        .sum_o(dpx_sum),
        .cout_o()
    );

    oag_adder #(.W(DATA_W)) u_xinc (
        .a_i(x_r),
        .b_i(X_STEP),
        .cin_i(1'b0),
        .sum_o(xinc_sum),
        .cout_o()
    );

    oag_ptr_fetch u_fetch (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .start_i(fetch_start),
        .ptr_i({REQ_I.op2, REQ_I.op1}),
        .mem_req_o(MEM_REQ_O),
        .mem_addr_o(MEM_ADDR_O),
        .mem_rdata_i(MEM_RDATA_I),
        .mem_rvalid_i(MEM_RVALID_I),
        .pc_load_o(PC_LOAD_O),
        .pc_o(PC_O),
        .idle_o(fetch_idle)
    );

    // APB decode: zero wait states, unmapped index answers with an error
    assign idx = PADDR_I[PADDR_W-1:2];
    assign mapped = idx == IDX_ACC || idx == IDX_XREG || idx == IDX_YREG ||
                    idx == IDX_PSW || idx == IDX_PAGE;
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && mapped;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign PRDATA_O = prdata_r;

    always_comb begin
        unique case (idx)
            IDX_ACC: rd_byte = acc_r;
            IDX_XREG: rd_byte = x_r;
            IDX_YREG: rd_byte = y_r;
            IDX_PSW: rd_byte = psw_r;
            IDX_PAGE: rd_byte = page_r;
            default: rd_byte = RESET_BYTE;
        endcase
    end

    // Read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            prdata_r <= '0;
        end else if (PSEL_I && !PENABLE_I) begin
            prdata_r <= {24'h000000, rd_byte};
        end
    end

    // A new request waits while a pointer fetch is in flight
    assign REQ_READY_O = fetch_idle;
    assign fire = REQ_VALID_I && fetch_idle;

    always_comb begin
        res_nxt = '0;
        res_nxt.operand = REQ_I.op1;
        unique case (REQ_I.mode)
            MODE_REG: begin
                res_nxt.operand = RESET_BYTE;
                unique case (REQ_I.reg_sel)
                    SEL_A: res_nxt.operand = acc_r;
                    SEL_X: res_nxt.operand = x_r;
                    SEL_Y: res_nxt.operand = y_r;
                    SEL_C: res_nxt.operand = {7'h00, psw_r[PSW_C_BIT]};
                    SEL_PSW: res_nxt.operand = psw_r;
                    default: res_nxt.illegal = 1'b1;
                endcase
                res_nxt.illegal = res_nxt.illegal ||
                    (REQ_I.op_class == CLS_RMW && REQ_I.reg_sel != SEL_A);
            end
            MODE_IMM: begin
                if (psw_r[PSW_G_BIT]) begin
                    res_nxt.addr = {page_r, REQ_I.op1};
                    res_nxt.mem = 1'b1;
                end
            end
            MODE_DP: begin
                res_nxt.addr = {page_r, REQ_I.op1};
                res_nxt.mem = 1'b1;
            end
            MODE_ABS: begin
                res_nxt.addr = {REQ_I.op2, REQ_I.op1};
                res_nxt.mem = 1'b1;
                res_nxt.rmw = REQ_I.op_class == CLS_RMW;
                res_nxt.illegal = REQ_I.op_class == CLS_XCHG || REQ_I.op_class == CLS_JUMP;
            end
            MODE_IDX_X: begin
                res_nxt.addr = {page_r, x_r};
                res_nxt.mem = 1'b1;
                res_nxt.illegal = REQ_I.op_class == CLS_RMW || REQ_I.op_class == CLS_JUMP;
            end
            MODE_IDX_X_INC: begin
                res_nxt.addr = {page_r, x_r};
                res_nxt.mem = 1'b1;
                res_nxt.illegal = REQ_I.op_class != CLS_LOAD && REQ_I.op_class != CLS_STORE;
            end
            MODE_IDX_X_DP: begin
                res_nxt.addr = {page_r, dpx_sum};
                res_nxt.mem = 1'b1;
                res_nxt.rmw = REQ_I.op_class == CLS_RMW;
            end
            MODE_ABS_IND: begin
                res_nxt.addr = {REQ_I.op2, REQ_I.op1};
                res_nxt.illegal = REQ_I.op_class != CLS_JUMP;
            end
        endcase
    end

    assign ok = fire && !res_nxt.illegal;
    assign fetch_start = ok && REQ_I.mode == MODE_ABS_IND;
    assign is_adc = ok && REQ_I.mode == MODE_IMM && REQ_I.opcode == OPC_ADC_IMM;
    assign is_asl = ok && REQ_I.mode == MODE_REG && REQ_I.op_class == CLS_RMW;
    assign is_inc = ok && REQ_I.mode == MODE_IDX_X_INC;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            res_r <= '0;
            res_valid_r <= 1'b0;
        end else begin
            res_valid_r <= fire;
            if (fire) begin
                res_r <= res_nxt;
            end
        end
    end

    assign RES_VALID_O = res_valid_r;
    assign RES_O = res_r;

    // Software writes win over same-cycle updates from an instruction
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            acc_r <= RESET_BYTE;
        end else if (apb_wr && idx == IDX_ACC) begin
            acc_r <= PWDATA_I[7:0];
        end else if (is_adc) begin
            acc_r <= adc_sum;
        end else if (is_asl) begin
            acc_r <= {acc_r[SHIFT_MSB-1:0], 1'b0};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            psw_r <= RESET_BYTE;
        end else if (apb_wr && idx == IDX_PSW) begin
            psw_r <= PWDATA_I[7:0];
        end else if (is_adc) begin
            psw_r[PSW_C_BIT] <= adc_cout;
        end else if (is_asl) begin
            psw_r[PSW_C_BIT] <= acc_r[SHIFT_MSB];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            x_r <= RESET_BYTE;
        end else if (apb_wr && idx == IDX_XREG) begin
            x_r <= PWDATA_I[7:0];
        end else if (is_inc) begin
            x_r <= xinc_sum;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            y_r <= RESET_BYTE;
            page_r <= RESET_BYTE;
        end else if (apb_wr && idx == IDX_YREG) begin
            y_r <= PWDATA_I[7:0];
        end else if (apb_wr && idx == IDX_PAGE) begin
            page_r <= PWDATA_I[7:0];
        end
    end

    property p_adc;
        @(posedge CLK_I) disable iff (RST_I)
        (is_adc && !apb_wr) |=> acc_r == 8'($past(acc_r) + $past(REQ_I.op1) + 8'($past(psw_r[PSW_C_BIT])));
    endproperty
    a_adc: assert property (p_adc) else $error("immediate add result wrong");

    property p_imm_value;
        @(posedge CLK_I) disable iff (RST_I)
        (fire && REQ_I.mode == MODE_IMM && !psw_r[PSW_G_BIT])
            |=> RES_VALID_O && !RES_O.mem && RES_O.operand == $past(REQ_I.op1);
    endproperty
    a_imm_value: assert property (p_imm_value) else $error("immediate operand wrong");

    property p_imm_page;
        @(posedge CLK_I) disable iff (RST_I)
        (fire && REQ_I.mode == MODE_IMM && psw_r[PSW_G_BIT])
            |=> RES_O.mem && RES_O.addr == {$past(page_r), $past(REQ_I.op1)};
    endproperty
    a_imm_page: assert property (p_imm_page) else $error("paged immediate address wrong");

    property p_dp;
        @(posedge CLK_I) disable iff (RST_I)
        (fire && REQ_I.mode == MODE_DP) |=> RES_O.addr == {$past(page_r), $past(REQ_I.op1)};
    endproperty
    a_dp: assert property (p_dp) else $error("direct page address wrong");

    property p_abs;
        @(posedge CLK_I) disable iff (RST_I)
        (fire && REQ_I.mode == MODE_ABS)
            |=> RES_O.addr == {$past(REQ_I.op2), $past(REQ_I.op1)} && RES_O.mem;
    endproperty
    a_abs: assert property (p_abs) else $error("absolute address wrong");

    property p_abs_rmw;
        @(posedge CLK_I) disable iff (RST_I)
        (fire && REQ_I.mode == MODE_ABS) |=> RES_O.rmw == ($past(REQ_I.op_class) == CLS_RMW);
    endproperty
    a_abs_rmw: assert property (p_abs_rmw) else $error("absolute read-modify-write flag wrong");

    property p_idx_x;
        @(posedge CLK_I) disable iff (RST_I)
        (fire && REQ_I.mode == MODE_IDX_X) |=> RES_O.addr == {$past(page_r), $past(x_r)};
    endproperty
    a_idx_x: assert property (p_idx_x) else $error("X indexed address wrong");

    property p_xinc;
        @(posedge CLK_I) disable iff (RST_I)
        (is_inc && !apb_wr) |=> RES_O.addr[7:0] == $past(x_r) && x_r == 8'($past(x_r) + 8'h01);
    endproperty
    a_xinc: assert property (p_xinc) else $error("auto increment wrong");

    property p_inc_class;
        @(posedge CLK_I) disable iff (RST_I)
        (fire && REQ_I.mode == MODE_IDX_X_INC && REQ_I.op_class != CLS_LOAD && REQ_I.op_class != CLS_STORE)
            |=> RES_O.illegal && (x_r == $past(x_r) || $past(apb_wr));
    endproperty
    a_inc_class: assert property (p_inc_class) else $error("auto increment accepted wrong class");

    property p_idx_dp;
        @(posedge CLK_I) disable iff (RST_I)
        (fire && REQ_I.mode == MODE_IDX_X_DP)
            |=> RES_O.addr == {$past(page_r), 8'($past(x_r) + $past(REQ_I.op1))};
    endproperty
    a_idx_dp: assert property (p_idx_dp) else $error("offset indexed address wrong");

    property p_asl;
        @(posedge CLK_I) disable iff (RST_I)
        (is_asl && !apb_wr) |=> acc_r == {$past(acc_r[6:0]), 1'b0} && x_r == $past(x_r) && y_r == $past(y_r);
    endproperty
    a_asl: assert property (p_asl) else $error("register shift wrong");
endmodule

// File: test/oag_tb.sv
/*
 Self-checking testbench for the operand address generator.
 Assumes the package and the design modules are compiled first; the bench
 drives APB, instruction requests and the pointer memory port itself.
*/
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import oag_pkg::*;

    logic clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic req_valid;
    logic req_ready;
    logic res_valid;
    req_t req;
    req_t r;
    res_t res;
    res_t res_o;
    logic mem_req;
    logic mem_rvalid = 1'b0;
    logic [DATA_W-1:0] mem_rdata = 8'h5A;
    logic [ADDR_W-1:0] mem_addr;
    logic pc_load;
    logic [ADDR_W-1:0] pc;
    logic [31:0] rdv;
    logic errv;
    logic busy;
    int num_errors = 0;
    int samples_checked = 0;
    logic [ADDR_W-1:0] fetched [$];
    logic [9:0] regs [5] = '{IDX_ACC, IDX_XREG, IDX_YREG, IDX_PSW, IDX_PAGE};
    op_class_t classes [5] = '{CLS_LOAD, CLS_STORE, CLS_CMP, CLS_ALU, CLS_RMW};
    reg_sel_t sels [5] = '{SEL_A, SEL_X, SEL_Y, SEL_C, SEL_PSW};
    logic [7:0] regv [5] = '{8'h11, 8'h22, 8'h33, 8'h01, 8'h21};

    operand_address_generator u_dut (
        .CLK_I(clk), .RST_I(rst),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .REQ_VALID_I(req_valid), .REQ_I(req), .REQ_READY_O(req_ready),
        .RES_VALID_O(res_valid), .RES_O(res_o),
        .MEM_REQ_O(mem_req), .MEM_ADDR_O(mem_addr), .MEM_RDATA_I(mem_rdata), .MEM_RVALID_I(mem_rvalid),
        .PC_LOAD_O(pc_load), .PC_O(pc)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Pointer memory answers one cycle late; idle data toggles so stale bytes are never mistaken
    always @(posedge clk) begin
        if (mem_req === 1'b1 && !mem_rvalid) begin
            mem_rvalid <= 1'b1;
            mem_rdata <= mem_addr[0] ? 8'hAB : 8'hCD;
            fetched.push_back(mem_addr);
        end else begin
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic res_ok(input string nm, input logic [15:0] a, input logic [2:0] f);
        check(nm, {16'h0, a}, {16'h0, res.addr});
        check(nm, {29'h0, f}, {29'h0, res.mem, res.rmw, res.illegal});
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the watchdog ends a wait for the slave
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic run(input req_t q);
        req <= q;
        req_valid <= 1'b1;
        @(posedge clk);
        while (req_ready !== 1'b1) begin
            @(posedge clk);
        end
        req_valid <= 1'b0;
        @(posedge clk);
        check("result valid", 32'h1, {31'h0, res_valid});
        res = res_o;
    endtask

    function automatic req_t mk(mode_t m, op_class_t c, reg_sel_t s, logic [7:0] o1, logic [7:0] o2);
        mk = '{m, c, s, 8'h00, o1, o2};
    endfunction

    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        req_valid = 1'b0;
        req = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0);
            check("reset value", 32'h0, rdv);
        end
        apb(1'b1, 10'h010, 32'hFF);
        check("unmapped write error", 32'h1, {31'h0, errv});
        apb(1'b0, 10'h010, 32'h0);
        check("unmapped read data", 32'h0, rdv);
        apb(1'b1, IDX_PAGE, 32'hFFFFFFA5);
        apb(1'b0, IDX_PAGE, 32'h0);
        check("page register", 32'hA5, rdv);
        run(mk(MODE_DP, CLS_LOAD, SEL_A, 8'h3C, 8'h00));
        res_ok("direct page", 16'hA53C, 3'b100);
        // Carry set, page-select clear
        apb(1'b1, IDX_PSW, 32'h01);
        apb(1'b1, IDX_ACC, 32'h10);
        r = mk(MODE_IMM, CLS_ALU, SEL_A, 8'h35, 8'h00);
        r.opcode = OPC_ADC_IMM;
        run(r);
        check("immediate operand", 32'h35, {24'h0, res.operand});
        check("immediate no memory", 32'h0, {31'h0, res.mem});
        apb(1'b0, IDX_ACC, 32'h0);
        check("add with carry", 32'h46, rdv);
        apb(1'b1, IDX_PSW, 32'h20);
        run(mk(MODE_IMM, CLS_LOAD, SEL_A, 8'h77, 8'h00));
        res_ok("paged immediate", 16'hA577, 3'b100);
        check("paged operand", 32'h77, {24'h0, res.operand});
        foreach (classes[i]) begin
            run(mk(MODE_ABS, classes[i], SEL_A, 8'h35, 8'h01));
            res_ok("absolute", 16'h0135, {1'b1, classes[i] == CLS_RMW, 1'b0});
        end
        run(mk(MODE_ABS, CLS_XCHG, SEL_A, 8'h35, 8'h01));
        check("absolute exchange", 32'h1, {31'h0, res.illegal});
        apb(1'b1, IDX_ACC, 32'h11);
        apb(1'b1, IDX_XREG, 32'h22);
        apb(1'b1, IDX_YREG, 32'h33);
        apb(1'b1, IDX_PSW, 32'h21);
        foreach (sels[i]) begin
            run(mk(MODE_REG, CLS_LOAD, sels[i], 8'h00, 8'h00));
            check("register operand", {24'h0, regv[i]}, {24'h0, res.operand});
            check("register no memory", 32'h0, {31'h0, res.mem});
        end
        // Shift left must leave X alone and move the old top bit into carry
        apb(1'b1, IDX_ACC, 32'h81);
        apb(1'b1, IDX_PSW, 32'h20);
        run(mk(MODE_REG, CLS_RMW, SEL_A, 8'h00, 8'h00));
        apb(1'b0, IDX_ACC, 32'h0);
        check("shift accumulator", 32'h02, rdv);
        apb(1'b0, IDX_PSW, 32'h0);
        check("shift carry", 32'h1, rdv & 32'h1);
        run(mk(MODE_REG, CLS_RMW, SEL_X, 8'h00, 8'h00));
        check("shift on X refused", 32'h1, {31'h0, res.illegal});
        apb(1'b0, IDX_XREG, 32'h0);
        check("X untouched", 32'h22, rdv);
        apb(1'b1, IDX_XREG, 32'h40);
        run(mk(MODE_IDX_X, CLS_XCHG, SEL_A, 8'h00, 8'h00));
        res_ok("x indexed", 16'hA540, 3'b100);
        run(mk(MODE_IDX_X, CLS_RMW, SEL_A, 8'h00, 8'h00));
        check("x indexed shift", 32'h1, {31'h0, res.illegal});
        apb(1'b1, IDX_XREG, 32'h10);
        run(mk(MODE_IDX_X_DP, CLS_LOAD, SEL_A, 8'hF8, 8'h00));
        res_ok("x plus offset", 16'hA508, 3'b100);
        // Back-to-back post-increment: the second access must see the stepped X
        apb(1'b1, IDX_XREG, 32'hFE);
        req <= mk(MODE_IDX_X_INC, CLS_LOAD, SEL_A, 8'h00, 8'h00);
        req_valid <= 1'b1;
        @(posedge clk);
        req <= mk(MODE_IDX_X_INC, CLS_STORE, SEL_A, 8'h00, 8'h00);
        @(posedge clk);
        req_valid <= 1'b0;
        check("first post increment", 32'hA5FE, {16'h0, res_o.addr});
        @(posedge clk);
        check("second post increment", 32'hA5FF, {16'h0, res_o.addr});
        apb(1'b0, IDX_XREG, 32'h0);
        check("X after two steps", 32'h00, rdv);
        run(mk(MODE_IDX_X_INC, CLS_ALU, SEL_A, 8'h00, 8'h00));
        check("post increment on ALU", 32'h1, {31'h0, res.illegal});
        apb(1'b0, IDX_XREG, 32'h0);
        check("X held when refused", 32'h00, rdv);
        fetched.delete();
        run(mk(MODE_ABS_IND, CLS_LOAD, SEL_A, 8'h34, 8'h12));
        check("indirect load", 32'h1, {31'h0, res.illegal});
        repeat (4) @(posedge clk);
        check("no pointer fetch", 32'h0, fetched.size());
        run(mk(MODE_ABS_IND, CLS_JUMP, SEL_A, 8'h34, 8'h12));
        busy = 1'b0;
        while (pc_load !== 1'b1) begin
            busy = busy | (req_ready === 1'b0);
            @(posedge clk);
        end
        check("jump target", 32'hABCD, {16'h0, pc});
        check("busy during fetch", 32'h1, {31'h0, busy});
        check("pointer low address", 32'h1234, {16'h0, fetched[0]});
        check("pointer high address", 32'h1235, {16'h0, fetched[1]});
        conclude();
    end
endmodule
